//--- inc/rtf_consts.svh
// constants for the transmit framing block
`ifndef RTF_CONSTS_SVH
`define RTF_CONSTS_SVH
// register indices; byte address is four times the index
`define RTF_IDX_LAST_BYTE 8'h2e
`define RTF_IDX_BURST     8'h30
`define RTF_IDX_GUARD_CTL 8'h31
`define RTF_IDX_GUARD_LO  8'h32
`define RTF_IDX_FRAME     8'h33
`define RTF_IDX_TX_DATA   8'h40
`define RTF_IDX_CONTROL   8'h41
`define RTF_IDX_STATUS    8'h42
// writable bit masks and guard control reset value
`define RTF_MASK_LAST_BYTE 8'h1f
`define RTF_MASK_BURST     8'h70
`define RTF_MASK_FRAME     8'hcf
`define RTF_RST_GUARD_CTL  8'hc0
// field positions
`define RTF_F_GRID      4
`define RTF_F_PAYLOAD   3
`define RTF_F_LASTBITS  2:0
`define RTF_F_BURSTLEN  6:4
`define RTF_F_GSTART    7
`define RTF_F_GUNIT     6
`define RTF_F_GUPPER    5:3
`define RTF_F_STOPGUARD 2:0
`define RTF_F_TXPAR     7
`define RTF_F_RXPAR     6
`define RTF_F_CLOSE     3:2
`define RTF_F_OPEN      1:0
`define RTF_F_GO        0
`define RTF_F_TYPEB     1
`define RTF_F_BURSTEN   2
`define RTF_F_LASTFLAG  8
// timing, byte length and response codes
`define RTF_GUARD_CARRIER_PERIODS 16
`define RTF_CARRIER_KHZ 13560
`define RTF_CLK_KHZ     25000
`define RTF_BYTE_BITS   9'h008
`define RTF_RESP_OKAY   2'h0
`define RTF_RESP_SLVERR 2'h2
`endif

//--- inc/rtf_pkg.sv
// types for the transmit framing block
package rtf_pkg;

  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_wait  = 3'h1,
    st_burst = 3'h3,
    st_open  = 3'h2,
    st_data  = 3'h6,
    st_par   = 3'h7,
    st_close = 3'h5,
    st_tail  = 3'h4
  } rtf_st_t;

  typedef enum logic [2:0] {
    kind_burst  = 3'h0,
    kind_sym0   = 3'h1,
    kind_sym1   = 3'h2,
    kind_sym2   = 3'h3,
    kind_data   = 3'h4,
    kind_parity = 3'h5,
    kind_stop   = 3'h6,
    kind_egt    = 3'h7
  } rtf_kind_t;

  typedef struct packed {
    rtf_st_t st; rtf_kind_t kind;
    logic ebit; logic evalid; logic busy; logic go_req;
    logic [7:0] last_ctl; logic [7:0] burst; logic [7:0] gctl;
    logic [7:0] glow; logic [7:0] frame;
    logic typeb; logic burst_en; logic par_err;
    logic aw_rdy; logic w_rdy; logic ar_rdy;
    logic aw_held; logic w_held; logic [11:0] awaddr;
    logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid; logic [1:0] bresp;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    logic [15:0] phase; logic [15:0] unit_cnt; logic [10:0] guard_cnt;
    logic [8:0] cnt; logic [7:0] sh; logic last; logic par;
    logic rx_valid; logic [7:0] rx_data;
  } rtf_state_t;

endpackage

//--- hw/rtf_fifo.sv
// first-in first-out buffer for transmit bytes
`timescale 1ns/100ps
module rtf_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 32
) (
  input  wire logic         aclk,      // system clock
  input  wire logic         aresetn,   // synchronous reset, active low
  input  wire logic         in_valid,  // write request
  output logic              in_ready,  // space available
  input  wire logic [W-1:0] in_data,   // write word
  output logic              out_valid, // word available
  input  wire logic         out_ready, // read acknowledge
  output logic [W-1:0]      out_data   // oldest word
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } rtf_fifo_st_t;

  rtf_fifo_st_t   r_reg;
  rtf_fifo_st_t   r_next;
  logic [W-1:0]   mem [DEPTH];
  logic           push;
  logic           pop;

  assign in_ready  = (r_reg.wp ^ r_reg.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = r_reg.wp != r_reg.rp;
  assign out_data  = mem[r_reg.rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[r_reg.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

//--- hw/rtf_framer.sv
// transmit framing control with AXI4-Lite register access
`timescale 1ns/100ps
`include "rtf_consts.svh"
module rtf_framer #(
  parameter int BIT_CYCLES = 944,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // synchronous reset, active low
  input  wire logic [11:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [11:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        rx_end,        // end of received data
  input  wire logic        rx_byte_valid, // received byte strobe
  input  wire logic [7:0]  rx_byte,       // received byte
  input  wire logic        rx_parity_bit, // received parity bit
  output logic             tx_elem_valid, // new element starts
  output logic [2:0]       tx_elem_kind,  // element kind
  output logic             tx_elem_bit,   // element bit value
  output logic             tx_busy,       // frame under way
  output logic             rx_data_valid, // byte to receive buffer
  output logic [7:0]       rx_data        // received byte
);
  localparam logic [15:0] ETU_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);
  localparam logic [15:0] CARRIER_UNIT = 16'(
    (`RTF_GUARD_CARRIER_PERIODS * `RTF_CLK_KHZ + `RTF_CARRIER_KHZ - 1)
    / `RTF_CARRIER_KHZ);

  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_etu
    $error("bit period must be 4 to 65535 cycles");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  function automatic logic [8:0] burst_bits(input logic [2:0] code);
    case (code)
      3'h0: return 9'h008;
      3'h1: return 9'h010;
      3'h2: return 9'h020;
      3'h3: return 9'h030;
      3'h4: return 9'h040;
      3'h5: return 9'h060;
      3'h6: return 9'h080;
      default: return 9'h100;
    endcase
  endfunction

  // first enabled frame stage at or after from; 5 means frame end
  function automatic logic [2:0] first_stage(input logic [4:0] en,
                                             input logic [2:0] from);
    logic [2:0] idx;
    idx = 3'h5;
    for (int i = 4; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic rtf_pkg::rtf_kind_t sym_kind(input logic [1:0] sel);
    case (sel)
      2'h1: return rtf_pkg::kind_sym0;
      2'h2: return rtf_pkg::kind_sym1;
      default: return rtf_pkg::kind_sym2;
    endcase
  endfunction

  // ****************************************
  // state and buffer
  // ****************************************
  rtf_pkg::rtf_state_t r_reg;
  rtf_pkg::rtf_state_t r_next;
  logic                fifo_in_ready;
  logic                fifo_push;
  logic                fifo_out_valid;
  logic                fifo_pop;
  logic [8:0]          fifo_out_data;
  logic [8:0]          fifo_in_data;
  logic [10:0]         guard_time;
  logic                guard_ok;
  logic                etu_end;
  logic [15:0]         unit_len;
  logic                wr_go;
  logic                is_data_wr;
  logic                tx_done;
  logic                byte_done;
  logic                load_byte;
  logic                adv;
  logic [2:0]          adv_from;
  logic [2:0]          stage;
  logic [4:0]          stage_en;

  rtf_fifo #(
    .W     (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  assign fifo_in_data = {r_reg.wstrb[1] & r_reg.wdata[`RTF_F_LASTFLAG],
                         r_reg.wdata[7:0]};
  assign guard_time = {r_reg.gctl[`RTF_F_GUPPER], r_reg.glow};
  assign guard_ok   = r_reg.guard_cnt >= guard_time;
  assign etu_end    = r_reg.phase == ETU_LAST;
  assign is_data_wr = r_reg.awaddr == reg_addr(`RTF_IDX_TX_DATA);
  // a data write stalls on a full buffer until space frees
  assign wr_go      = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid
                      && (!is_data_wr || fifo_in_ready);
  assign fifo_push  = wr_go && is_data_wr && r_reg.wstrb[0];
  // guard unit: carrier based or half a bit period
  assign unit_len   = r_reg.gctl[`RTF_F_GUNIT] ? HALF_BIT : CARRIER_UNIT;
  assign stage_en   = {
    r_reg.typeb && (r_reg.gctl[`RTF_F_STOPGUARD] != 3'h0),
    r_reg.frame[`RTF_F_CLOSE] != 2'h0,
    r_reg.last_ctl[`RTF_F_PAYLOAD] && fifo_out_valid,
    r_reg.frame[`RTF_F_OPEN] != 2'h0,
    r_reg.burst_en};
  assign stage = first_stage(stage_en, adv_from);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    r_next.evalid = 1'b0;
    r_next.rx_valid = 1'b0;
    adv = 1'b0;
    adv_from = 3'h0;
    byte_done = 1'b0;
    load_byte = 1'b0;
    tx_done = 1'b0;
    fifo_pop = 1'b0;

    // register writes
    if (s_axi_awvalid && r_reg.aw_rdy) begin
      r_next.aw_held = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.w_rdy) begin
      r_next.w_held = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = `RTF_RESP_OKAY;
      case (r_reg.awaddr)
        reg_addr(`RTF_IDX_LAST_BYTE): begin
          if (r_reg.wstrb[0]) begin
            r_next.last_ctl = r_reg.wdata[7:0] & `RTF_MASK_LAST_BYTE;
          end
        end
        reg_addr(`RTF_IDX_BURST): begin
          if (r_reg.wstrb[0]) begin
            r_next.burst = r_reg.wdata[7:0] & `RTF_MASK_BURST;
          end
        end
        reg_addr(`RTF_IDX_GUARD_CTL): begin
          if (r_reg.wstrb[0]) begin
            r_next.gctl = r_reg.wdata[7:0];
          end
        end
        reg_addr(`RTF_IDX_GUARD_LO): begin
          if (r_reg.wstrb[0]) begin
            r_next.glow = r_reg.wdata[7:0];
          end
        end
        reg_addr(`RTF_IDX_FRAME): begin
          if (r_reg.wstrb[0]) begin
            r_next.frame = r_reg.wdata[7:0] & `RTF_MASK_FRAME;
          end
        end
        reg_addr(`RTF_IDX_TX_DATA): begin
        end
        reg_addr(`RTF_IDX_CONTROL): begin
          if (r_reg.wstrb[0]) begin
            r_next.typeb = r_reg.wdata[`RTF_F_TYPEB];
            r_next.burst_en = r_reg.wdata[`RTF_F_BURSTEN];
            if (r_reg.wdata[`RTF_F_GO]) begin
              r_next.go_req = 1'b1;
            end
          end
        end
        reg_addr(`RTF_IDX_STATUS): begin
          if (r_reg.wstrb[0] && r_reg.wdata[4]) begin
            r_next.par_err = 1'b0;
          end
        end
        default: r_next.bresp = `RTF_RESP_SLVERR;
      endcase
    end
    r_next.aw_rdy = !r_next.aw_held;
    r_next.w_rdy = !r_next.w_held;

    // register reads
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.ar_rdy) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = `RTF_RESP_OKAY;
      r_next.rdata = 32'h0;
      case (s_axi_araddr)
        reg_addr(`RTF_IDX_LAST_BYTE): r_next.rdata[7:0] = r_reg.last_ctl;
        reg_addr(`RTF_IDX_BURST):     r_next.rdata[7:0] = r_reg.burst;
        reg_addr(`RTF_IDX_GUARD_CTL): r_next.rdata[7:0] = r_reg.gctl;
        reg_addr(`RTF_IDX_GUARD_LO):  r_next.rdata[7:0] = r_reg.glow;
        reg_addr(`RTF_IDX_FRAME):     r_next.rdata[7:0] = r_reg.frame;
        reg_addr(`RTF_IDX_TX_DATA):   r_next.rdata = 32'h0;
        reg_addr(`RTF_IDX_CONTROL): begin
          r_next.rdata[`RTF_F_TYPEB] = r_reg.typeb;
          r_next.rdata[`RTF_F_BURSTEN] = r_reg.burst_en;
        end
        reg_addr(`RTF_IDX_STATUS): begin
          r_next.rdata[4:0] = {r_reg.par_err, guard_ok, !fifo_out_valid,
                               !fifo_in_ready, r_reg.busy};
        end
        default: r_next.rresp = `RTF_RESP_SLVERR;
      endcase
    end
    r_next.ar_rdy = !r_next.rvalid;

    // bit period phase and guard unit
    r_next.phase = etu_end ? 16'h0 : r_reg.phase + 16'h1;
    if (r_reg.unit_cnt >= unit_len - 16'h1) begin
      r_next.unit_cnt = 16'h0;
      // saturates, so raising the guard later keeps elapsed time
      if (~&r_reg.guard_cnt) begin
        r_next.guard_cnt = r_reg.guard_cnt + 11'h1;
      end
    end else begin
      r_next.unit_cnt = r_reg.unit_cnt + 16'h1;
    end

    // frame sequencer
    case (r_reg.st)
      rtf_pkg::st_idle: begin
        if (r_reg.go_req) begin
          r_next.go_req = 1'b0;
          r_next.busy = 1'b1;
          r_next.st = rtf_pkg::st_wait;
        end
      end
      rtf_pkg::st_wait: begin
        if (guard_ok && (!r_reg.last_ctl[`RTF_F_GRID] || etu_end)) begin
          r_next.phase = 16'h0;
          adv = 1'b1;
          adv_from = 3'h0;
        end
      end
      rtf_pkg::st_burst: begin
        if (etu_end) begin
          if (r_reg.cnt > 9'h1) begin
            r_next.cnt = r_reg.cnt - 9'h1;
            r_next.evalid = 1'b1;
          end else begin
            adv = 1'b1;
            adv_from = 3'h1;
          end
        end
      end
      rtf_pkg::st_open: begin
        if (etu_end) begin
          adv = 1'b1;
          adv_from = 3'h2;
        end
      end
      rtf_pkg::st_data: begin
        if (etu_end) begin
          if (r_reg.cnt > 9'h1) begin
            r_next.cnt = r_reg.cnt - 9'h1;
            r_next.sh = r_reg.sh >> 1;
            r_next.ebit = r_reg.sh[1];
            r_next.par = r_reg.par ^ r_reg.sh[1];
            r_next.evalid = 1'b1;
          end else if (r_reg.frame[`RTF_F_TXPAR]) begin
            r_next.st = rtf_pkg::st_par;
            r_next.kind = rtf_pkg::kind_parity;
            r_next.ebit = r_reg.par;
            r_next.evalid = 1'b1;
          end else begin
            byte_done = 1'b1;
          end
        end
      end
      rtf_pkg::st_par: begin
        byte_done = etu_end;
      end
      rtf_pkg::st_close: begin
        if (etu_end) begin
          adv = 1'b1;
          adv_from = 3'h4;
        end
      end
      rtf_pkg::st_tail: begin
        if (etu_end) begin
          if (r_reg.cnt != 9'h0) begin
            r_next.cnt = r_reg.cnt - 9'h1;
            r_next.kind = rtf_pkg::kind_egt;
            r_next.ebit = 1'b1;
            r_next.evalid = 1'b1;
          end else begin
            adv = 1'b1;
            adv_from = 3'h5;
          end
        end
      end
      default: r_next.st = rtf_pkg::st_idle;
    endcase

    if (byte_done) begin
      if (!r_reg.last && fifo_out_valid) begin
        load_byte = 1'b1;
      end else begin
        adv = 1'b1;
        adv_from = 3'h3;
      end
    end

    if (adv) begin
      r_next.evalid = 1'b1;
      case (stage)
        3'h0: begin
          r_next.st = rtf_pkg::st_burst;
          r_next.kind = rtf_pkg::kind_burst;
          r_next.ebit = 1'b1;
          r_next.cnt = burst_bits(r_reg.burst[`RTF_F_BURSTLEN]);
        end
        3'h1: begin
          r_next.st = rtf_pkg::st_open;
          r_next.kind = sym_kind(r_reg.frame[`RTF_F_OPEN]);
          r_next.ebit = 1'b0;
        end
        3'h2: begin
          r_next.evalid = 1'b0;
          load_byte = 1'b1;
        end
        3'h3: begin
          r_next.st = rtf_pkg::st_close;
          r_next.kind = sym_kind(r_reg.frame[`RTF_F_CLOSE]);
          r_next.ebit = 1'b0;
        end
        3'h4: begin
          r_next.st = rtf_pkg::st_tail;
          r_next.kind = rtf_pkg::kind_stop;
          r_next.ebit = 1'b1;
          r_next.cnt = {6'h0, r_reg.gctl[`RTF_F_STOPGUARD] - 3'h1};
        end
        default: begin
          r_next.evalid = 1'b0;
          r_next.st = rtf_pkg::st_idle;
          r_next.busy = 1'b0;
          tx_done = 1'b1;
        end
      endcase
    end

    if (load_byte) begin
      fifo_pop = 1'b1;
      r_next.st = rtf_pkg::st_data;
      r_next.kind = rtf_pkg::kind_data;
      r_next.sh = fifo_out_data[7:0];
      r_next.last = fifo_out_data[`RTF_F_LASTFLAG];
      r_next.ebit = fifo_out_data[0];
      r_next.par = ~fifo_out_data[0];
      r_next.evalid = 1'b1;
      r_next.cnt = `RTF_BYTE_BITS;
      if (fifo_out_data[`RTF_F_LASTFLAG]
          && r_reg.last_ctl[`RTF_F_LASTBITS] != 3'h0) begin
        r_next.cnt = {6'h0, r_reg.last_ctl[`RTF_F_LASTBITS]};
      end
    end

    // guard restart point
    if ((rx_end && r_reg.gctl[`RTF_F_GSTART])
        || (tx_done && !r_reg.gctl[`RTF_F_GSTART])) begin
      r_next.guard_cnt = 11'h0;
      r_next.unit_cnt = 16'h0;
    end

    // receive path, parity kept out of the data
    if (rx_byte_valid) begin
      r_next.rx_valid = 1'b1;
      r_next.rx_data = rx_byte;
      if (r_reg.frame[`RTF_F_RXPAR] && !(^{rx_byte, rx_parity_bit})) begin
        r_next.par_err = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.gctl <= `RTF_RST_GUARD_CTL;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = r_reg.aw_rdy;
  assign s_axi_wready  = r_reg.w_rdy;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_arready = r_reg.ar_rdy;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign tx_elem_valid = r_reg.evalid;
  assign tx_elem_kind  = r_reg.kind;
  assign tx_elem_bit   = r_reg.ebit;
  assign tx_busy       = r_reg.busy;
  assign rx_data_valid = r_reg.rx_valid;
  assign rx_data       = r_reg.rx_data;
endmodule

//--- verif/rtf_framer_properties.sv
// port assertions for the transmit framing block
`timescale 1ns/100ps
module rtf_framer_props #(
  parameter int BIT_CYCLES = 944
) (
  input logic       aclk,          // clock
  input logic       aresetn,       // reset, active low
  input logic       s_axi_arvalid, // read addr valid
  input logic       s_axi_arready, // read addr ready
  input logic       s_axi_rvalid,  // read data valid
  input logic       s_axi_bvalid,  // write resp valid
  input logic       s_axi_bready,  // write resp ready
  input logic       rx_byte_valid, // rx byte strobe
  input logic [7:0] rx_byte,       // rx byte
  input logic       rx_data_valid, // byte to buffer
  input logic [7:0] rx_data,       // byte to buffer
  input logic       tx_elem_valid, // element start
  input logic [2:0] tx_elem_kind,  // element kind
  input logic       tx_elem_bit,   // element bit
  input logic       tx_busy        // frame under way
);
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since the last element start, saturating
  always_comb gap_next = tx_elem_valid ? 16'h0 :
    gap_reg + {15'h0, gap_reg != 16'hffff};
  always_ff @(posedge aclk) gap_reg <= aresetn ? gap_next : 16'hffff;
  AST_RD_LAT:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AR_BLOCK:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read data");
  AST_WR_CLR:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_RX_ECHO:
    assert property (rx_byte_valid |=>
      rx_data_valid && rx_data == $past(rx_byte)) else $error("rx byte lost");
  AST_ELEM_BUSY:
    assert property (tx_elem_valid |-> tx_busy)
    else $error("element outside frame");
  AST_ELEM_GAP:
    assert property (tx_elem_valid |-> gap_reg >= BIT_CYCLES - 1)
    else $error("element too short");
  AST_SYM_LOW:
    assert property (tx_elem_valid && tx_elem_kind inside {3'h1, 3'h2, 3'h3}
      |-> !tx_elem_bit) else $error("symbol bit not low");
  AST_BURST_HIGH:
    assert property (tx_elem_valid && tx_elem_kind == 3'h0 |-> tx_elem_bit)
    else $error("burst bit not high");
  AST_TAIL_HIGH:
    assert property (tx_elem_valid && tx_elem_kind[2:1] == 2'h3
      |-> tx_elem_bit) else $error("stop or guard bit not high");
  AST_KIND_HOLD:
    assert property (tx_busy && $past(tx_busy) && !tx_elem_valid
      |-> $stable(tx_elem_kind)) else $error("kind moved inside element");
  cover property (tx_elem_valid && tx_elem_kind == 3'h7);
  cover property (tx_elem_valid && tx_elem_kind == 3'h5);
  cover property (rx_data_valid);
endmodule
bind rtf_framer rtf_framer_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (.*);

//--- verif/rtf_card.sv
// contactless card stand-in: logs elements, answers a frame
`timescale 1ns/100ps
module rtf_card (
  input  logic       aclk,          // clock
  input  logic       tx_elem_valid, // element start
  input  logic [2:0] tx_elem_kind,  // element kind
  input  logic       tx_elem_bit,   // element bit
  input  logic       tx_busy,       // frame under way
  input  int         reply_dly,     // answer delay, 0 none
  input  logic       bad_par,       // answer with wrong parity
  output logic       rx_end,        // end of answer
  output logic       rx_byte_valid, // answer byte strobe
  output logic [7:0] rx_byte,       // answer byte
  output logic       rx_parity_bit  // answer parity
);
  logic [3:0] log[$];
  logic       busy_q = 1'b0;
  int         cnt = 0;
  initial {rx_end, rx_byte_valid, rx_byte, rx_parity_bit} = 11'h0;
  always @(posedge aclk) begin
    busy_q <= tx_busy;
    rx_end <= rx_byte_valid;
    rx_byte_valid <= cnt == 1;
    if (tx_elem_valid) log.push_back({tx_elem_kind, tx_elem_bit});
    if (busy_q && !tx_busy && reply_dly != 0) cnt <= reply_dly;
    else if (cnt != 0) cnt <= cnt - 1;
    // idle lines toggle so a stale value is never mistaken for data
    rx_byte <= cnt == 1 ? 8'h5a : ~rx_byte;
    rx_parity_bit <= cnt == 1 ? 1'b1 ^ bad_par : ~rx_parity_bit;
  end
endmodule

//--- verif/tb_rf_tx_frame_config.sv
// self-checking bench for the transmit framing block
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  miscompares++; $display("Error %s expected %0h seen %0h", n, e, s); end end
module tb_rf_tx_frame_config;
  logic        aclk = 1'b0, aresetn = 1'b0, bad_par = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, rx_end, rx_byte_valid, rx_parity_bit;
  logic        tx_elem_valid, tx_elem_bit, tx_busy, rx_data_valid;
  logic [7:0]  rx_byte, rx_data;
  logic [2:0]  tx_elem_kind;
  logic [3:0]  xq[$];
  int          miscompares = 0, samples_checked = 0, cyc = 0, t1 = 0;
  int          reply_dly = 0;
  rtf_framer #(.BIT_CYCLES(8), .FIFO_DEPTH(32)) DUT (.*);
  rtf_card card (.*);
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (tx_elem_valid) t1 <= cyc;
  end
  task automatic wr(input logic [7:0] i, input logic [31:0] d,
                    input logic [3:0] s = 4'h1);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      a |= s_axi_awready;
      w |= s_axi_wready;
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    `CHK("bresp", 2'h0, s_axi_bresp)
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rchk(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(i, d, r);
    `CHK($sformatf("reg %h", i), e, d)
  endtask
  task automatic px(input logic [2:0] k, input logic b, input int n = 1);
    repeat (n) xq.push_back({k, b});
  endtask
  task automatic pb(input logic [7:0] v, input int n, input logic p);
    for (int b = 0; b < n; b++) px(3'h4, v[b]);
    if (p) px(3'h5, ~^(v & 8'(255 >> (8 - n))));
  endtask
  task automatic run(input logic [7:0] c);
    card.log.delete();
    wr(8'h41, {24'h0, c});
    while (!tx_busy) @(posedge aclk);
    while (tx_busy) @(posedge aclk);
    `CHK("element count", xq.size(), card.log.size())
    foreach (xq[k]) `CHK("element", xq[k], card.log[k])
    xq.delete();
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    int          bl[8] = '{8, 16, 32, 48, 64, 96, 128, 256};
    logic [31:0] d;
    logic [1:0]  r;
    int          t0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(8'h31, 32'hc0);
    rd(8'h20, d, r);
    `CHK("unmapped resp", 2'h2, r)
    wr(8'h2e, 32'hff);
    wr(8'h30, 32'hff);
    wr(8'h33, 32'hff);
    rchk(8'h2e, 32'h1f);
    rchk(8'h30, 32'h70);
    rchk(8'h33, 32'hcf);
    $display("test registers done");
    wr(8'h31, 32'h0);
    wr(8'h32, 32'h0);
    wr(8'h30, 32'h0);
    wr(8'h2e, 32'h0b);
    for (int c = 0; c < 4; c++) begin
      wr(8'h33, c * 5);
      wr(8'h40, 32'h1b2, 4'h3);
      if (c != 0) px(3'(c), 1'b0);
      pb(8'hb2, 3, 1'b0);
      if (c != 0) px(3'(c), 1'b0);
      run(8'h01);
    end
    $display("test symbols done");
    wr(8'h2e, 32'h18);
    wr(8'h33, 32'h80);
    for (int k = 0; k < 8; k++) begin
      wr(8'h30, k * 16);
      wr(8'h31, k);
      wr(8'h40, 32'h103, 4'h3);
      px(3'h0, 1'b1, bl[k]);
      pb(8'h03, 8, 1'b1);
      if (k != 0) px(3'h6, 1'b1);
      if (k > 1) px(3'h7, 1'b1, k - 1);
      run(8'h07);
    end
    $display("test codes done");
    wr(8'h30, 32'h0);
    wr(8'h31, 32'h0);
    wr(8'h33, 32'h0);
    for (int k = 0; k < 32; k++) begin
      wr(8'h40, k == 31 ? 32'h11f : k, 4'h3);
      pb(8'(k), 8, 1'b0);
    end
    rd(8'h42, d, r);
    `CHK("fifo full", 32'h2, d & 32'h6)
    run(8'h01);
    rd(8'h42, d, r);
    `CHK("fifo empty", 32'h4, d & 32'h6)
    $display("test fifo done");
    wr(8'h2e, 32'h0);
    wr(8'h33, 32'h41);
    wr(8'h31, 32'hc8);
    wr(8'h32, 32'h02);
    wr(8'h40, 32'h1b2, 4'h3);
    reply_dly <= 5;
    bad_par <= 1'b1;
    px(3'h1, 1'b0);
    run(8'h01);
    while (!rx_end) @(posedge aclk);
    t0 = cyc;
    reply_dly <= 0;
    px(3'h1, 1'b0);
    run(8'h01);
    `CHK("guard", 1'b1, t1 - t0 >= 1032 && t1 - t0 <= 1060)
    rd(8'h42, d, r);
    `CHK("rx parity", 32'h10, d & 32'h10)
    $display("test guard done");
    report_and_stop;
  end
endmodule
